// >>> odt_pkg.sv
/*
 * Package for the on-die termination timing block: register map, field
 * positions, reset values, latency adders and shared types.
 * Assumes a 32-bit APB register bus and one command clock.
 */
`default_nettype none
package odt_pkg;
	localparam int LAT_W = 7;

	// register byte addresses
	localparam logic [7:0] ADDR_LAT  = 8'h00;
	localparam logic [7:0] ADDR_TERM = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;

	// latency register fields
	localparam int LAT_CWL_LSB = 0;
	localparam int LAT_AL_LSB  = 8;
	localparam int LAT_PL_LSB  = 16;
	localparam int LAT_CL_LSB  = 24;

	// termination register fields
	localparam int TERM_NOM_LSB   = 0;
	localparam int TERM_WR_LSB    = 4;
	localparam int TERM_PARK_LSB  = 8;
	localparam int TERM_PRE2_BIT  = 12;
	localparam int TERM_CRC_BIT   = 13;
	localparam int TERM_BURST_LSB = 16;

	// burst mode encodings
	localparam logic [1:0] BURST_BL8 = 2'h0;
	localparam logic [1:0] BURST_OTF = 2'h1;
	localparam logic [1:0] BURST_BC4 = 2'h2;

	// reset values: write latency 9, read latency 11, all termination off
	localparam logic [31:0] RST_LAT  = 32'h0B000009;
	localparam logic [31:0] RST_TERM = 32'h00000000;

	// latency adders
	localparam logic [LAT_W-1:0] SUB_PRE1    = 7'h02;
	localparam logic [LAT_W-1:0] SUB_PRE2    = 7'h03;
	localparam logic [LAT_W-1:0] RD_ON4_PRE1 = 7'h04;
	localparam logic [LAT_W-1:0] RD_ON4_PRE2 = 7'h05;
	localparam logic [LAT_W-1:0] RD_ON8_PRE1 = 7'h06;
	localparam logic [LAT_W-1:0] RD_ON8_PRE2 = 7'h07;
	// write return adders indexed by {pre2, crc}
	localparam logic [3:0][LAT_W-1:0] WR_RET4 = {7'h08, 7'h05, 7'h07, 7'h04};
	localparam logic [3:0][LAT_W-1:0] WR_RET8 = {7'h08, 7'h07, 7'h07, 7'h06};

	// history entry bits
	localparam int E_PIN  = 0;
	localparam int E_RD   = 1;
	localparam int E_WR   = 2;
	localparam int E_CHOP = 3;
	localparam int E_W    = 4;

	typedef enum logic [1:0] {
		ODT_OFF  = 2'b00,
		ODT_WR   = 2'b01,
		ODT_NOM  = 2'b10,
		ODT_PARK = 2'b11
	} odt_term_t;

	// difference, never below one cycle
	function automatic logic [LAT_W-1:0] odt_sub(input logic [LAT_W-1:0] a,
		input logic [LAT_W-1:0] b);
		odt_sub = (a > b + 7'h01) ? a - b : 7'h01;
	endfunction : odt_sub
endpackage : odt_pkg
`default_nettype wire

// >>> odt_lat_if.sv
/*
 * Carrier of the computed termination latencies between the latency
 * calculator and the main block. Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface odt_lat_if;
	logic [odt_pkg::LAT_W-1:0] direct;
	logic [odt_pkg::LAT_W-1:0] rd_off;
	logic [odt_pkg::LAT_W-1:0] rd_on4;
	logic [odt_pkg::LAT_W-1:0] rd_on8;
	logic [odt_pkg::LAT_W-1:0] cnw;
	logic [odt_pkg::LAT_W-1:0] cwn4;
	logic [odt_pkg::LAT_W-1:0] cwn8;

	modport src (output direct, rd_off, rd_on4, rd_on8, cnw, cwn4, cwn8);
	modport snk (input direct, rd_off, rd_on4, rd_on8, cnw, cwn4, cwn8);
endinterface : odt_lat_if
`default_nettype wire

// >>> odt_lat.sv
/*
 * Latency calculator: turns the programmed latency, preamble and CRC
 * settings into cycle counts. Assumes settings are stable register values.
 */
`timescale 1ns/1ps
`default_nettype none
module odt_lat (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [5:0] write_cas_latency,
	input  wire logic [5:0] al,
	input  wire logic [3:0] pl,
	input  wire logic [5:0] cl,
	input  wire logic       pre2,
	input  wire logic       crc,
	odt_lat_if.src          lat
);
	typedef struct packed {
		logic [odt_pkg::LAT_W-1:0] direct;
		logic [odt_pkg::LAT_W-1:0] rd_off;
		logic [odt_pkg::LAT_W-1:0] rd_on4;
		logic [odt_pkg::LAT_W-1:0] rd_on8;
		logic [odt_pkg::LAT_W-1:0] cnw;
		logic [odt_pkg::LAT_W-1:0] cwn4;
		logic [odt_pkg::LAT_W-1:0] cwn8;
	} odt_lat_t;

	odt_lat_t state;
	odt_lat_t next_state;

	// recomputed every cycle so a settings write affects later commands
	always_comb begin
		logic [odt_pkg::LAT_W-1:0] wl;
		logic [odt_pkg::LAT_W-1:0] rl;
		logic [odt_pkg::LAT_W-1:0] sub;
		logic [1:0]                sel;
		wl = 7'(write_cas_latency) + 7'(al) + 7'(pl);
		rl = 7'(cl) + 7'(al) + 7'(pl);
		sub = pre2 ? odt_pkg::SUB_PRE2 : odt_pkg::SUB_PRE1;
		sel = {pre2, crc};
		next_state.direct = odt_pkg::odt_sub(wl, sub);
		next_state.rd_off = odt_pkg::odt_sub(rl, sub);
		next_state.rd_on4 = next_state.rd_off +
			(pre2 ? odt_pkg::RD_ON4_PRE2 : odt_pkg::RD_ON4_PRE1);
		next_state.rd_on8 = next_state.rd_off +
			(pre2 ? odt_pkg::RD_ON8_PRE2 : odt_pkg::RD_ON8_PRE1);
		next_state.cnw = odt_pkg::odt_sub(wl, sub);
		next_state.cwn4 = next_state.cnw + odt_pkg::WR_RET4[sel];
		next_state.cwn8 = next_state.cnw + odt_pkg::WR_RET8[sel];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign lat.direct = state.direct;
	assign lat.rd_off = state.rd_off;
	assign lat.rd_on4 = state.rd_on4;
	assign lat.rd_on8 = state.rd_on8;
	assign lat.cnw    = state.cnw;
	assign lat.cwn4   = state.cwn4;
	assign lat.cwn8   = state.cwn8;
endmodule : odt_lat
`default_nettype wire

// >>> odt_hist.sv
/*
 * Event history: a shift line of per-cycle pin and command samples.
 * Entry k holds what was registered k+1 edges before the current one.
 */
`timescale 1ns/1ps
`default_nettype none
module odt_hist #(
	parameter int DEPTH = 64,
	parameter int W     = 4
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [W-1:0]              din,
	output logic      [DEPTH-1:0][W-1:0]   line
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] line;
	} odt_hist_t;

	odt_hist_t state;
	odt_hist_t next_state;

	// newest sample enters at slot zero
	always_comb begin
		next_state.line = {state.line[DEPTH-2:0], din};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign line = state.line;
endmodule : odt_hist
`default_nettype wire

// >>> odt_sync_dynamic_timing.sv
/*
 * Synchronous and dynamic on-die termination timing with an APB slave for
 * the termination and latency settings. Assumes pin and command inputs are
 * synchronous to pclk, one command per cycle, decoded by the caller.
 */
//
// Contract
// - synchronous termination timing whenever the delay-locked loop is enabled and locked
// - synchronous timing holds in active, refresh, idle and both power-down states
// - nominal termination follows the pin after turn-on and turn-off latencies
// - direct latencies are write+additive+parity latency minus two or three
// - read turns termination off after read latency sum minus two or three
// - park restores after read off latency plus 4/5 chop-4, 6/7 otherwise; on-the-fly chop-4 reads get 6/7
// - never terminate while driving read data; re-enable after the postamble
// - dynamic switching enabled when either low write-termination field bit is set
// - nominal, write and park values come from their mode register fields
// - without writes nominal follows pin latencies, park applies while pin low
// - any write selects write termination at the write-change latency
// - write termination deselected after burst-8 or chop-4 return latency
// - write-change latency is write latency minus two or three
// - return latency adds 4/7/5/8 chop-4 or 6/7/7/8 burst-8
// - no dynamic switching while the delay-locked loop is off
// - priority: disabled, write, nominal, park termination
// - ignore the pin when nominal field is zero or in self refresh
`timescale 1ns/1ps
`default_nettype none
module odt_sync_dynamic_timing #(
	parameter int DEPTH = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        term_pin,
	input  wire logic        cmd_read,
	input  wire logic        cmd_write,
	input  wire logic        cmd_chop,
	input  wire logic        dll_enabled,
	input  wire logic        dll_locked,
	input  wire logic        self_refresh,
	output logic      [1:0]  term_state,
	output logic      [2:0]  term_value,
	output logic             term_on,
	output logic             sync_mode
);
	// the history must hold the longest return latency reachable; the
	// upper bound keeps the slot index inside the latency width
	if (DEPTH < 8 || DEPTH > 128) begin : g_depth_check
		$error("odt_sync_dynamic_timing: DEPTH must lie in 8..128");
	end

	// all state in one record: settings, bus reply and resolved termination
	typedef struct packed {
		logic [31:0]       lat_reg;
		logic [31:0]       term_reg;
		logic [31:0]       rdata;
		logic              ack;
		odt_pkg::odt_term_t term;
		logic [2:0]        value;
		logic              sync;
	} odt_main_t;

	odt_main_t state;
	odt_main_t next_state;

	// computed latencies; they trail a settings write by one edge
	odt_lat_if lat ();

	// one sample per edge of pin and commands, newest in slot zero
	logic [DEPTH-1:0][odt_pkg::E_W-1:0] hist;
	logic [odt_pkg::E_W-1:0]            entry;

	// decoded settings
	logic [2:0] nom_field;
	logic [2:0] wr_field;
	logic [2:0] park_field;
	logic [1:0] burst_mode;
	logic       pre2;
	logic       crc;

	assign nom_field  = state.term_reg[odt_pkg::TERM_NOM_LSB +: 3];
	assign wr_field   = state.term_reg[odt_pkg::TERM_WR_LSB +: 3];
	assign park_field = state.term_reg[odt_pkg::TERM_PARK_LSB +: 3];
	assign burst_mode = state.term_reg[odt_pkg::TERM_BURST_LSB +: 2];
	assign pre2       = state.term_reg[odt_pkg::TERM_PRE2_BIT];
	assign crc        = state.term_reg[odt_pkg::TERM_CRC_BIT];

	// settings reach the calculator as fields; a write just before a
	// command is harmless as long as one edge separates them
	odt_lat u_lat (
		.pclk    (pclk),
		.presetn (presetn),
		.write_cas_latency     (state.lat_reg[odt_pkg::LAT_CWL_LSB +: 6]),
		.al      (state.lat_reg[odt_pkg::LAT_AL_LSB +: 6]),
		.pl      (state.lat_reg[odt_pkg::LAT_PL_LSB +: 4]),
		.cl      (state.lat_reg[odt_pkg::LAT_CL_LSB +: 6]),
		.pre2    (pre2),
		.crc     (crc),
		.lat     (lat.src)
	);

	// chop per command: fixed chop mode, or the on-the-fly selection
	// frozen per command, so a later burst mode write cannot stretch a write window
	// that is already running
	always_comb begin
		entry = '0;
		entry[odt_pkg::E_PIN] = term_pin;
		entry[odt_pkg::E_RD]  = cmd_read;
		entry[odt_pkg::E_WR]  = cmd_write;
		entry[odt_pkg::E_CHOP] = (burst_mode == odt_pkg::BURST_BC4) ||
			((burst_mode == odt_pkg::BURST_OTF) && cmd_chop);
	end

	// the window scan below reads every slot of this line
	odt_hist #(
		.DEPTH (DEPTH),
		.W     (odt_pkg::E_W)
	) u_hist (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (entry),
		.line    (hist)
	);

	// apb decode; one wait state so read data comes from a flip-flop
	logic access;
	logic addr_ok;

	assign access  = psel && penable;
	assign addr_ok = (paddr == odt_pkg::ADDR_LAT) || (paddr == odt_pkg::ADDR_TERM) ||
		(paddr == odt_pkg::ADDR_STAT);
	assign pready  = access && state.ack;
	// unmapped offsets answer with an error and read as zero
	assign pslverr = access && state.ack && !addr_ok;

	// true while an event of the given age lies inside [from, upto)
	function automatic logic odt_in_window(input int age, input int from, input int upto);
		odt_in_window = (age >= from) && (age < upto);
	endfunction : odt_in_window

	// termination window evaluation over the history
	logic       rd_quiet;
	logic       wr_win;
	logic       pin_late;
	logic       dyn_en;
	logic       sync;
	logic       pin_used;
	int         didx;

	always_comb begin
		int on_lat;
		int off_lat;
		on_lat   = 0;
		off_lat  = 0;
		rd_quiet = 1'b0;
		wr_win   = 1'b0;
		// commands may overlap, so every slot is scanned each cycle
		for (int k = 0; k < DEPTH; k++) begin
			// read keeps termination off until its postamble has ended
			if (hist[k][odt_pkg::E_RD]) begin
				off_lat = int'(lat.rd_off);
				on_lat = (burst_mode == odt_pkg::BURST_BC4) ? int'(lat.rd_on4) :
					int'(lat.rd_on8);
				if (odt_in_window(k + 1, off_lat, on_lat)) begin
					rd_quiet = 1'b1;
				end
			end
			// write window from change latency up to return latency
			if (hist[k][odt_pkg::E_WR]) begin
				off_lat = int'(lat.cnw);
				on_lat = hist[k][odt_pkg::E_CHOP] ? int'(lat.cwn4) : int'(lat.cwn8);
				if (odt_in_window(k + 1, off_lat, on_lat)) begin
					wr_win = 1'b1;
				end
			end
		end
	end

	// both direct latencies are equal, so one delayed tap serves on and off
	// the clamp keeps the tap valid while latencies are zero after reset
	always_comb begin
		didx = int'(lat.direct) - 1;
		if (didx > DEPTH - 1) begin
			didx = DEPTH - 1; // limitation: longer latencies saturate
		end
		if (didx < 0) begin
			didx = 0;
		end
	end

	// mode and enable decode; a write field of four alone stays static
	assign sync     = dll_enabled && dll_locked;
	assign dyn_en   = sync && (wr_field[0] || wr_field[1]);
	assign pin_used = (nom_field != 3'h0) && !self_refresh;
	// outside synchronous mode the pin acts without latency
	assign pin_late = sync ? hist[didx][odt_pkg::E_PIN] : term_pin;

	// next state: register file and resolved termination
	always_comb begin
		next_state = state;
		next_state.sync = sync;
		// register access
		// read data taken at the first access edge of a read or a write, held until the next access
		if (access && !state.ack) begin
			next_state.ack = 1'b1;
			case (paddr)
				odt_pkg::ADDR_LAT: begin
					next_state.rdata = state.lat_reg;
				end
				odt_pkg::ADDR_TERM: begin
					next_state.rdata = state.term_reg;
				end
				odt_pkg::ADDR_STAT: begin
					next_state.rdata = {26'h0, state.sync, state.term, state.value};
				end
				default: begin
					next_state.rdata = 32'h00000000;
				end
			endcase
		end else begin
			next_state.ack = 1'b0;
		end
		// writes land at the completing edge only
		// reserved bits masked so a read returns only live fields
		if (pready && pwrite) begin
			case (paddr)
				odt_pkg::ADDR_LAT: begin
					next_state.lat_reg = pwdata & 32'h3F0F3F3F;
				end
				odt_pkg::ADDR_TERM: begin
					next_state.term_reg = pwdata & 32'h00033777;
				end
				default: begin
					next_state.lat_reg = state.lat_reg;
				end
			endcase
		end
		// priority: off, write, nominal, park
		// self refresh and the read window both force the output stage off
		if (self_refresh) begin
			next_state.term = odt_pkg::ODT_OFF; // not supported in self refresh
		end else if (rd_quiet) begin
			next_state.term = odt_pkg::ODT_OFF;
		end else if (dyn_en && wr_win && wr_field != 3'h0) begin
			next_state.term = odt_pkg::ODT_WR;
		end else if (pin_used && pin_late) begin
			next_state.term = odt_pkg::ODT_NOM;
		end else if (park_field != 3'h0) begin
			next_state.term = odt_pkg::ODT_PARK;
		end else begin
			next_state.term = odt_pkg::ODT_OFF;
		end
		// value follows the winning source; off shows zero
		case (next_state.term)
			odt_pkg::ODT_WR: begin
				next_state.value = wr_field;
			end
			odt_pkg::ODT_NOM: begin
				next_state.value = nom_field;
			end
			odt_pkg::ODT_PARK: begin
				next_state.value = park_field;
			end
			default: begin
				next_state.value = 3'h0;
			end
		endcase
	end

	// single state register; reset puts the settings at their defaults
	// and the termination off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.lat_reg  <= odt_pkg::RST_LAT;
			state.term_reg <= odt_pkg::RST_TERM;
			state.rdata    <= 32'h00000000;
			state.ack      <= 1'b0;
			state.term     <= odt_pkg::ODT_OFF;
			state.value    <= 3'h0;
			state.sync     <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flip-flops, except the on flag and the bus ready and error, plain decodes
	assign prdata     = state.rdata;
	assign term_state = state.term;
	assign term_value = state.value;
	assign term_on    = (state.term != odt_pkg::ODT_OFF);
	assign sync_mode  = state.sync;
endmodule : odt_sync_dynamic_timing
`default_nettype wire

// >>> odt_sync_dynamic_timing_sva.sv
/* checker: bus handshake, loop-lock mode and read/write windows.
   assumes settings change only through completed bus writes. */
`timescale 1ns/1ps
`default_nettype none
module odt_chk #(
	parameter int DEPTH = 64
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        term_pin,
	input wire logic        cmd_read,
	input wire logic        cmd_write,
	input wire logic        cmd_chop,
	input wire logic        dll_enabled,
	input wire logic        dll_locked,
	input wire logic        self_refresh,
	input wire logic [1:0]  term_state,
	input wire logic [2:0]  term_value,
	input wire logic        term_on,
	input wire logic        sync_mode
);
	logic [31:0] s_lat;
	logic [31:0] s_term;
	logic [6:0]  rd_cnt;
	logic [6:0]  wr_cnt;
	logic [6:0]  sub;
	logic [6:0]  cnw;
	logic [6:0]  roff;
	logic [6:0]  ron;
	logic        wdone;
	// mirrored settings; command age saturates so old commands stay quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_lat <= 32'h0B000009;
			s_term <= 32'h00000000;
			rd_cnt <= 7'h00;
			wr_cnt <= 7'h00;
		end else begin
			if (wdone && paddr == 8'h00) s_lat <= pwdata & 32'h3F0F3F3F;
			if (wdone && paddr == 8'h04) s_term <= pwdata & 32'h00033777;
			rd_cnt <= cmd_read ? 7'h01 : rd_cnt + 7'(rd_cnt != 7'h00 && rd_cnt != 7'h7F);
			wr_cnt <= cmd_write ? 7'h01 : wr_cnt + 7'(wr_cnt != 7'h00 && wr_cnt != 7'h7F);
		end
	end
	// latencies from the settings in force
	assign wdone = psel && penable && pready && pwrite;
	assign sub = s_term[12] ? 7'h03 : 7'h02;
	assign cnw = 7'(s_lat[5:0]) + 7'(s_lat[13:8]) + 7'(s_lat[19:16]) - sub;
	assign roff = cnw - 7'(s_lat[5:0]) + 7'(s_lat[29:24]);
	assign ron = roff + sub + (s_term[17:16] == 2'h2 ? 7'h02 : 7'h04);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sync_on: assert property (dll_enabled && dll_locked |=> sync_mode)
		else $error("sync mode missing");
	a_sync_off: assert property (!dll_locked |=> !sync_mode)
		else $error("sync mode without lock");
	a_selfref_off: assert property (self_refresh |=> term_state == 2'b00)
		else $error("termination in self refresh");
	a_on_decode: assert property (term_on == (term_state != 2'b00))
		else $error("on flag wrong");
	a_park_value: assert property (
		term_state == 2'b11 && $past(s_term, 3) == s_term |-> term_value == s_term[10:8])
		else $error("park value wrong");
	a_pready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not after one wait");
	a_read_quiet: assert property (
		sync_mode && rd_cnt > roff && rd_cnt <= ron |-> term_state == 2'b00)
		else $error("termination while driving");
	a_write_on: assert property (
		sync_mode && s_term[5:4] != 2'b00 && wr_cnt == cnw + 7'h01 |-> term_state == 2'b01)
		else $error("write termination late");
	c_read: cover property (rd_cnt == ron);
	c_write: cover property (term_state == 2'b01);
	c_err: cover property (pslverr);
endmodule : odt_chk
bind odt_sync_dynamic_timing odt_chk #(.DEPTH(DEPTH)) i_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.term_pin(term_pin), .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_chop(cmd_chop),
	.dll_enabled(dll_enabled), .dll_locked(dll_locked), .self_refresh(self_refresh),
	.term_state(term_state), .term_value(term_value), .term_on(term_on), .sync_mode(sync_mode)
);
`default_nettype wire

// >>> odt_ctl_model.sv
/* controller model: termination pin and one-cycle command pulses.
   assumes its tasks are called just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module odt_ctl_model #(
	parameter int MIN_HOLD = 8
) (
	input  wire logic pclk,
	output logic      term_pin,
	output logic      cmd_read,
	output logic      cmd_write,
	output logic      cmd_chop
);
	logic rq_rd;
	logic rq_wr;
	logic rq_chop;
	int   hi_cnt;
	initial begin
		term_pin = 1'b0;
		cmd_read = 1'b0;
		cmd_write = 1'b0;
		cmd_chop = 1'b0;
		rq_rd = 1'b0;
		rq_wr = 1'b0;
		hi_cnt = 0;
	end
	// pulses leave at the edge after a request; chop flips when meaningless
	always @(posedge pclk) begin
		cmd_read <= rq_rd;
		cmd_write <= rq_wr;
		cmd_chop <= (rq_rd || rq_wr) ? rq_chop : ~cmd_chop;
		hi_cnt <= term_pin ? hi_cnt + 1 : 0;
		rq_rd = 1'b0;
		rq_wr = 1'b0;
	end
	task automatic issue(input logic rd, input logic wr, input logic chop);
		rq_rd = rd;
		rq_wr = wr;
		rq_chop = chop;
		@(posedge pclk);
		#1;
	endtask : issue
	// margin over the shortest hold covers crc and the long preamble
	task automatic set_pin(input logic v);
		while (!v && term_pin && hi_cnt < MIN_HOLD) @(posedge pclk);
		@(posedge pclk);
		term_pin <= v;
		#1;
	endtask : set_pin
endmodule : odt_ctl_model
`default_nettype wire

// >>> testbench.sv
/* bench: bus tasks, pin and command windows checked cycle by cycle.
   assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        dll_enabled = 1'b1;
	logic        dll_locked = 1'b1;
	logic        self_refresh = 1'b0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, term_on, sync_mode;
	logic        term_pin, cmd_read, cmd_write, cmd_chop;
	logic [1:0]  term_state;
	logic [2:0]  term_value;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          t0, l, k;
	int          ret4[4] = '{4, 7, 5, 8};
	int          ret8[4] = '{6, 7, 7, 8};
	odt_sync_dynamic_timing i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.term_pin(term_pin), .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_chop(cmd_chop),
		.dll_enabled(dll_enabled), .dll_locked(dll_locked), .self_refresh(self_refresh),
		.term_state(term_state), .term_value(term_value), .term_on(term_on), .sync_mode(sync_mode)
	);
	odt_ctl_model i_ctl (.pclk(pclk), .term_pin(term_pin), .cmd_read(cmd_read),
		.cmd_write(cmd_write), .cmd_chop(cmd_chop));
	always #25 pclk = ~pclk;
	// edge count for windows; the ceiling cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// old state at edge t0+n, new one an edge later
	task automatic win(input int n, input logic [1:0] s0, input logic [1:0] s1);
		while (cyc < t0 + n) begin
			@(posedge pclk);
			#1;
		end
		cmp({30'h0, term_state}, {30'h0, s0});
		@(posedge pclk);
		#1;
		cmp({30'h0, term_state}, {30'h0, s1});
		cmp({31'h0, term_on}, {31'h0, s1 != 2'h0});
	endtask : win
	// one bus transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		cmp(32'(n), 32'h2); // one wait state, then ready
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		cmp(rd, 32'h0B000009);
		apb(1'b0, 8'h0C, 32'h0);
		cmp({31'h0, er}, 32'h1);
		apb(1'b1, 8'h08, 32'hFFFFFFFF);
		apb(1'b0, 8'h08, 32'h0);
		cmp(rd, 32'h00000020);
		$display("register test done");
		// pin windows at two latency and preamble settings
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, 8'h00, 32'h0B000009 + 32'(i * 512));
			apb(1'b1, 8'h04, 32'h00000201 + 32'(i * 4096));
			l = 7 + i;
			i_ctl.set_pin(1'b1);
			t0 = cyc;
			win(l, 2'h3, 2'h2);
			cmp({29'h0, term_value}, 32'h1);
			i_ctl.set_pin(1'b0);
			t0 = cyc;
			win(l, 2'h2, 2'h3);
			cmp({29'h0, term_value}, 32'h2);
		end
		apb(1'b1, 8'h00, 32'h0B000009);
		$display("pin test done");
		// write windows: each preamble, crc and burst selection, chop always asked
		for (int j = 0; j < 12; j++) begin
			apb(1'b1, 8'h04, 32'h00000321 | 32'((j % 4) << 12) | 32'((j / 4) << 16));
			k = (j % 2) * 2 + (j / 2) % 2;
			l = 7 - j % 2;
			i_ctl.issue(1'b0, 1'b1, 1'b1);
			t0 = cyc;
			win(l, 2'h3, 2'h1);
			cmp({29'h0, term_value}, 32'h2);
			win(l + (j < 4 ? ret8[k] : ret4[k]), 2'h1, 2'h3);
		end
		$display("write test done");
		// read windows: off while data is driven, park back after
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, 8'h04, 32'h00000301 | 32'((j % 2) << 12) | 32'((j / 2) << 17));
			l = 9 - j % 2;
			i_ctl.issue(1'b1, 1'b0, 1'b0);
			t0 = cyc;
			win(l, 2'h3, 2'h0);
			win(l + (j < 2 ? 6 : 4) + j % 2, 2'h0, 2'h3);
		end
		$display("read test done");
		// writes and pin that must be ignored
		apb(1'b1, 8'h04, 32'h00000341);
		i_ctl.issue(1'b0, 1'b1, 1'b0);
		t0 = cyc;
		win(7, 2'h3, 2'h3);
		apb(1'b1, 8'h04, 32'h00000301);
		i_ctl.issue(1'b0, 1'b1, 1'b0);
		t0 = cyc;
		win(7, 2'h3, 2'h3);
		apb(1'b1, 8'h04, 32'h00000321);
		@(posedge pclk);
		dll_locked <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		cmp({31'h0, sync_mode}, 32'h0);
		i_ctl.issue(1'b0, 1'b1, 1'b0);
		t0 = cyc;
		win(7, 2'h3, 2'h3);
		@(posedge pclk);
		dll_locked <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		cmp({31'h0, sync_mode}, 32'h1);
		@(posedge pclk);
		dll_enabled <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		cmp({31'h0, sync_mode}, 32'h0);
		@(posedge pclk);
		dll_enabled <= 1'b1;
		apb(1'b1, 8'h04, 32'h00000320);
		i_ctl.set_pin(1'b1);
		t0 = cyc;
		win(7, 2'h3, 2'h3);
		@(posedge pclk);
		self_refresh <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		cmp({30'h0, term_state}, 32'h0);
		@(posedge pclk);
		self_refresh <= 1'b0;
		i_ctl.set_pin(1'b0);
		$display("refusal test done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
